// >>> hw/bfs_pkg.sv
// Package for the breaker failure supervisor: register map, field layouts,
// modes, states and timing constants.
// Assumes a single 125 MHz system clock and an APB register port.
package bfs_pkg;
    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DELAY = 8'h04;
    localparam logic [7:0] ADDR_CMAP = 8'h08;
    localparam logic [7:0] ADDR_EMAP = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_CMD = 8'h14;
    localparam logic [7:0] ADDR_TIMER = 8'h18;
    // Status and command field positions.
    localparam int STAT_TRIP_BIT = 4;
    localparam int STAT_LOCK_BIT = 5;
    localparam int STAT_TRIG_BIT = 6;
    localparam int STAT_STOP_BIT = 7;
    localparam int CMD_CLRLOCK_BIT = 0;
    // Clock period and default supervision delay.
    localparam int CLK_PERIOD_NS = 8;
    localparam int DELAY_RESET_NS = 100000;
    localparam int DELAY_RESET_CYC = DELAY_RESET_NS / CLK_PERIOD_NS;
    localparam logic [31:0] MAP_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        SCH_CURRENT = 2'h0,
        SCH_POSITION = 2'h1,
        SCH_COMBINED = 2'h2
    } bfs_scheme_t;

    typedef enum logic [1:0] {
        TRG_ALL = 2'h0,
        TRG_CURRENT = 2'h1,
        TRG_EXTERNAL = 2'h2,
        TRG_NONE = 2'h3
    } bfs_trig_t;

    typedef enum logic [3:0] {
        ST_STANDBY = 4'b0001,
        ST_RUNNING = 4'b0010,
        ST_REJECTED = 4'b0100,
        ST_TRIPPED = 4'b1000
    } bfs_state_t;

    typedef struct packed {
        logic [1:0] brkSel;
        bfs_trig_t trigMode;
        bfs_scheme_t scheme;
        logic enable;
    } bfs_ctrl_t;

    localparam bfs_ctrl_t CTRL_RESET = '{2'h0, TRG_ALL, SCH_CURRENT, 1'b0};

    // Inputs of one breaker: position contacts and undercurrent comparator.
    typedef struct packed {
        logic closed;
        logic open;
        logic underCur;
    } bfs_brk_t;
endpackage

// >>> hw/bfs_supervisor.sv
// Breaker failure supervisor with an APB register slave.
// Assumes trip, position and comparator inputs synchronous to sys_clk.
// Operation
// [RULE1] Position and combined schemes start only with breaker closed, in stand-by.
// [RULE2] Current-only scheme starts on trigger in stand-by, position ignored.
// [RULE3] Trigger mode selects all, current-only or external-only trips.
// [RULE4] Trips not mapped to the supervised breaker are ignored.
// [RULE5] Breaker select picks which breaker's position and current are used.
// [RULE6] Position-only scheme stops the timer on breaker open.
// [RULE7] Current-only scheme stops the timer on undercurrent.
// [RULE8] Combined scheme stops only on open and undercurrent together.
// [RULE9] A stopped timer enters rejected and never trips.
// [RULE10] Rejected returns to stand-by once all triggers drop.
// [RULE11] Timer expiry declares failure and raises the upstream trip.
// [RULE12] Position-only: trip drops on breaker open and triggers gone.
// [RULE13] Current-only: trip drops on undercurrent and triggers gone.
// [RULE14] Combined: trip drops on open, undercurrent and triggers gone.
// [RULE15] Software sets the delay to the backup protection's minimum delay.
// [RULE16] Timer keeps running after the trigger drops.
// [RULE17] Lockout sets with the trip and holds until acknowledged or reset.
// [RULE18] Delay is a programmable count; reset gives stand-by, no trip.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module bfs_supervisor
    import bfs_pkg::*;
#(
    parameter int NBRK = 2,
    parameter int NTRIP = 8,
    parameter logic [31:0] DELAY_RESET = 32'(DELAY_RESET_CYC)
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Trip manager
    input wire logic [NTRIP-1:0] curTrip,
    input wire logic [NTRIP-1:0] extTrip,
    // Breaker inputs
    input wire bfs_brk_t [NBRK-1:0] brkIn,
    // Outputs
    output logic upTrip,
    output logic lockout
);
    if (NBRK < 1 || NBRK > 4) begin : g_bad_nbrk
        $error("NBRK must be 1 to 4");
    end
    if (NTRIP < 1 || NTRIP > 32) begin : g_bad_ntrip
        $error("NTRIP must be 1 to 32");
    end

    // An out-of-range select falls back to breaker 0 rather than reading nothing.
    function automatic bfs_brk_t pickBrk(input bfs_brk_t [NBRK-1:0] b, input logic [1:0] s);
        bfs_brk_t r;
        r = b[0];
        if (32'(s) < NBRK) begin
            r = b[s];
        end
        return r;
    endfunction

    bfs_ctrl_t ctrl;
    bfs_ctrl_t next_ctrl;
    logic [31:0] delay;
    logic [31:0] next_delay;
    logic [NTRIP-1:0] cMap;
    logic [NTRIP-1:0] next_cMap;
    logic [NTRIP-1:0] eMap;
    logic [NTRIP-1:0] next_eMap;
    logic [31:0] next_prdata;
    bfs_state_t state;
    bfs_state_t next_state;
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic next_lockout;
    logic wrEn;
    logic rdEn;
    logic mapped;
    logic clrLock;
    logic trig;
    logic stopCond;
    logic posClosed;
    logic posOpen;
    bfs_brk_t brk;

    // The slave never waits, so every access completes in two cycles.
    assign pready = 1'b1;
    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && !penable && !pwrite;
    assign clrLock = wrEn && paddr == ADDR_CMD && pwdata[CMD_CLRLOCK_BIT];
    assign upTrip = state == ST_TRIPPED;

    always_comb begin
        unique case (paddr)
            ADDR_CTRL, ADDR_DELAY, ADDR_CMAP, ADDR_EMAP: mapped = 1'b1;
            ADDR_STATUS, ADDR_CMD, ADDR_TIMER: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !mapped;

    always_comb begin
        next_ctrl = ctrl;
        next_delay = delay;
        next_cMap = cMap;
        next_eMap = eMap;
        next_prdata = prdata;
        if (wrEn) begin
            unique case (paddr)
                ADDR_CTRL: next_ctrl = bfs_ctrl_t'(pwdata[6:0]);
                ADDR_DELAY: next_delay = pwdata;
                ADDR_CMAP: next_cMap = pwdata[NTRIP-1:0];
                ADDR_EMAP: next_eMap = pwdata[NTRIP-1:0];
                default: next_delay = delay;
            endcase
        end
        // Read data is captured in the setup cycle so it comes from a flop.
        if (rdEn) begin
            next_prdata = 32'h0000_0000;
            unique case (paddr)
                ADDR_CTRL: next_prdata[6:0] = ctrl;
                ADDR_DELAY: next_prdata = delay;
                ADDR_CMAP: next_prdata[NTRIP-1:0] = cMap;
                ADDR_EMAP: next_prdata[NTRIP-1:0] = eMap;
                ADDR_STATUS: begin
                    next_prdata[3:0] = state;
                    next_prdata[STAT_TRIP_BIT] = upTrip;
                    next_prdata[STAT_LOCK_BIT] = lockout;
                    next_prdata[STAT_TRIG_BIT] = trig;
                    next_prdata[STAT_STOP_BIT] = stopCond;
                end
                ADDR_TIMER: next_prdata = cnt;
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ctrl <= CTRL_RESET;
            delay <= DELAY_RESET; // [RULE18]
            cMap <= MAP_RESET[NTRIP-1:0];
            eMap <= MAP_RESET[NTRIP-1:0];
            prdata <= 32'h0000_0000;
        end else begin
            ctrl <= next_ctrl;
            delay <= next_delay;
            cMap <= next_cMap;
            eMap <= next_eMap;
            prdata <= next_prdata;
        end
    end

    // Trigger qualification and breaker evaluation.
    always_comb begin
        brk = pickBrk(brkIn, ctrl.brkSel); // [RULE5]
        posClosed = brk.closed && !brk.open;
        posOpen = brk.open && !brk.closed;
        unique case (ctrl.trigMode) // [RULE3]
            TRG_ALL: trig = |(curTrip & cMap) || |(extTrip & eMap); // [RULE4]
            TRG_CURRENT: trig = |(curTrip & cMap);
            TRG_EXTERNAL: trig = |(extTrip & eMap);
            TRG_NONE: trig = 1'b0;
        endcase
        unique case (ctrl.scheme)
            SCH_CURRENT: stopCond = brk.underCur; // [RULE7] [RULE13]
            SCH_POSITION: stopCond = posOpen; // [RULE6] [RULE12]
            // The unused scheme code behaves as the combined scheme.
            default: stopCond = posOpen && brk.underCur; // [RULE8] [RULE14]
        endcase
    end

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_lockout = lockout;
        if (clrLock) begin
            next_lockout = 1'b0;
        end
        unique case (state)
            ST_STANDBY: begin
                if (ctrl.enable && trig && (ctrl.scheme == SCH_CURRENT || posClosed)) begin
                    // [RULE1] [RULE2]
                    next_state = ST_RUNNING;
                    next_cnt = delay;
                end
            end
            ST_RUNNING: begin
                // The trigger is not looked at here: a dropped trip keeps timing.
                if (stopCond) begin
                    next_state = ST_REJECTED; // [RULE9]
                    next_cnt = 32'h0000_0000;
                end else if (cnt <= 32'h0000_0001) begin
                    next_state = ST_TRIPPED; // [RULE11]
                    next_cnt = 32'h0000_0000;
                    next_lockout = 1'b1; // [RULE17]
                end else begin
                    next_cnt = cnt - 32'h0000_0001; // [RULE16]
                end
            end
            ST_REJECTED: begin
                if (!trig) begin
                    next_state = ST_STANDBY; // [RULE10]
                end
            end
            ST_TRIPPED: begin
                if (stopCond && !trig) begin
                    next_state = ST_STANDBY; // [RULE12] [RULE13] [RULE14]
                end
            end
        endcase
        // Disabling the function abandons supervision but keeps the lockout.
        if (!ctrl.enable) begin
            next_state = ST_STANDBY;
            next_cnt = 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state <= ST_STANDBY; // [RULE18]
            cnt <= 32'h0000_0000;
            lockout <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            lockout <= next_lockout;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    sequence sIdleTrig;
        state == ST_STANDBY && ctrl.enable && trig;
    endsequence
    sequence sTimerDone;
        state == ST_RUNNING && cnt <= 32'h0000_0001 && !stopCond && ctrl.enable;
    endsequence

    chk_start_needs_closed: assert property ( // [RULE1]
        sIdleTrig and (ctrl.scheme != SCH_CURRENT && !posClosed) |=> state == ST_STANDBY
    ) else $error("timer started with breaker not closed");
    chk_start_current: assert property ( // [RULE2]
        sIdleTrig and ctrl.scheme == SCH_CURRENT |=> state == ST_RUNNING && cnt == $past(delay)
    ) else $error("current scheme did not start timer");
    chk_unmapped_quiet: assert property ( // [RULE4]
        cMap == '0 && eMap == '0 |-> !trig
    ) else $error("unmapped trip raised a trigger");
    chk_stop_rejects: assert property ( // [RULE9]
        state == ST_RUNNING && stopCond && ctrl.enable |=> state == ST_REJECTED ##1 !upTrip
    ) else $error("stopped timer did not reject");
    chk_reject_exit: assert property ( // [RULE10]
        state == ST_REJECTED && !trig && ctrl.enable |=> state == ST_STANDBY
    ) else $error("rejected state did not return to stand-by");
    chk_expiry_trips: assert property ( // [RULE11]
        sTimerDone |=> upTrip && lockout
    ) else $error("expiry did not trip upstream");
    chk_trip_holds: assert property ( // [RULE12] [RULE13] [RULE14]
        upTrip && ctrl.enable && !(stopCond && !trig) |=> upTrip
    ) else $error("upstream trip dropped early");
    chk_timer_runs: assert property ( // [RULE16]
        state == ST_RUNNING && !stopCond && ctrl.enable && cnt > 32'h0000_0001
            |=> state == ST_RUNNING && cnt == $past(cnt) - 32'h0000_0001
    ) else $error("timer did not keep running");
    chk_lock_latched: assert property ( // [RULE17]
        lockout && !clrLock |=> lockout
    ) else $error("lockout cleared without acknowledge");
    chk_delay_length: assert property ( // [RULE18]
        (state == ST_RUNNING && cnt == 32'h0000_0003 && ctrl.enable && !stopCond)
            ##1 (ctrl.enable && !stopCond)[*2] |=> upTrip
    ) else $error("supervision delay count wrong");
endmodule
`default_nettype wire

// >>> verification/bfs_brk_model.sv
// Breaker model: position contacts and undercurrent comparator of one breaker.
// Assumes open and current commands from the bench, synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module bfs_brk_model
    import bfs_pkg::*;
#(
    parameter int OPEN_DLY = 2
) (
    // Clock
    input wire logic sys_clk,
    // Bench commands
    input wire logic cmdOpen,
    input wire logic curHigh,
    // Breaker signals
    output bfs_brk_t brkOut
);
    logic [OPEN_DLY-1:0] pipe = '0;
    always @(posedge sys_clk) begin
        pipe <= {pipe[OPEN_DLY-2:0], cmdOpen};
    end
    // Mid-travel both contacts read low, so neither position is reported.
    assign brkOut.closed = !cmdOpen && !pipe[OPEN_DLY-1];
    assign brkOut.open = cmdOpen && pipe[OPEN_DLY-1];
    // A stuck current reading keeps the undercurrent comparator low even with contacts open.
    assign brkOut.underCur = pipe[OPEN_DLY-1] && !curHigh;
endmodule
`default_nettype wire

// >>> verification/breaker_failure_supervisor_tb.sv
// Testbench for the breaker failure supervisor over APB.
// Assumes zero-wait APB and two modelled breakers.
`timescale 1ns/1ps
`default_nettype none
module breaker_failure_supervisor_tb;
    import bfs_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] curTrip = 8'h00;
    logic [7:0] extTrip = 8'h00;
    wire bfs_brk_t [1:0] brkIn;
    logic upTrip;
    logic lockout;
    logic [1:0] cmdOpen = 2'b00;
    logic [1:0] curHigh = 2'b00;
    logic lastErr;
    logic [31:0] v;
    int n;
    int miscompares = 0;
    int compares = 0;
    always #4 sys_clk = ~sys_clk;
    bfs_supervisor #(.NBRK(2), .NTRIP(8), .DELAY_RESET(32'h6)) DUT (.sys_clk(sys_clk),
        .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .curTrip(curTrip), .extTrip(extTrip), .brkIn(brkIn), .upTrip(upTrip),
        .lockout(lockout));
    bfs_brk_model b0 (.sys_clk(sys_clk), .cmdOpen(cmdOpen[0]), .curHigh(curHigh[0]),
        .brkOut(brkIn[0]));
    bfs_brk_model b1 (.sys_clk(sys_clk), .cmdOpen(cmdOpen[1]), .curHigh(curHigh[1]),
        .brkOut(brkIn[1]));
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        v = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic state_is(input logic [3:0] e);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("state", {28'h0, e}, {28'h0, v[3:0]});
    endtask
    task automatic pulse(input logic [7:0] c, input logic [7:0] x);
        @(posedge sys_clk);
        curTrip <= c;
        extTrip <= x;
        @(posedge sys_clk);
        curTrip <= 8'h00;
        extTrip <= 8'h00;
        #1;
    endtask
    task automatic wait_trip();
        n = 0;
        while (upTrip !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask
    task automatic t_reset();
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl", 32'h0, v);
        apb(1'b0, ADDR_DELAY, 32'h0);
        chk("delay", 32'h6, v);
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", 32'h1, {31'h0, lastErr});
        chk("uptrip", 32'h0, {31'h0, upTrip});
    endtask
    task automatic t_current();
        apb(1'b1, ADDR_CMAP, 32'h1);
        apb(1'b1, ADDR_EMAP, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h1);
        pulse(8'h01, 8'h00);
        wait_trip();
        chk("delay cycles", 32'h6, n);
        chk("lockout", 32'h1, {31'h0, lockout});
        cmdOpen[0] <= 1'b1;
        repeat (5) @(posedge sys_clk);
        #1;
        chk("uptrip drop", 32'h0, {31'h0, upTrip});
        chk("lock held", 32'h1, {31'h0, lockout});
        apb(1'b1, ADDR_CMD, 32'h1);
        #1;
        chk("lock clear", 32'h0, {31'h0, lockout});
        cmdOpen[0] <= 1'b0;
    endtask
    task automatic t_modes();
        logic [1:0] md [9] = '{0, 0, 1, 1, 2, 2, 0, 0, 3};
        logic [7:0] ct [9] = '{1, 0, 1, 0, 0, 1, 2, 0, 1};
        logic [7:0] et [9] = '{0, 1, 0, 1, 1, 0, 0, 2, 1};
        logic [3:0] ex [9] = '{2, 2, 2, 1, 2, 1, 1, 1, 1};
        apb(1'b1, ADDR_DELAY, 32'd40);
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, ADDR_CTRL, {27'h0, md[i], 3'h1});
            pulse(ct[i], et[i]);
            state_is(ex[i]);
            apb(1'b1, ADDR_CTRL, 32'h0);
        end
    endtask
    task automatic t_reject();
        apb(1'b1, ADDR_CTRL, 32'h3);
        curTrip <= 8'h01;
        // The breaker must still read closed at the edge that starts the timer.
        @(posedge sys_clk);
        cmdOpen[0] <= 1'b1;
        repeat (5) @(posedge sys_clk);
        state_is(4'h4);
        chk("no trip", 32'h0, {31'h0, upTrip});
        curTrip <= 8'h00;
        state_is(4'h1);
        pulse(8'h01, 8'h00);
        state_is(4'h1);
        cmdOpen[0] <= 1'b0;
    endtask
    task automatic t_combined();
        apb(1'b1, ADDR_DELAY, 32'd12);
        apb(1'b1, ADDR_CTRL, 32'h5);
        curHigh[0] <= 1'b1;
        pulse(8'h01, 8'h00);
        cmdOpen[0] <= 1'b1;
        wait_trip();
        chk("combined trip", 32'd12, n);
        repeat (4) @(posedge sys_clk);
        #1;
        chk("trip held", 32'h1, {31'h0, upTrip});
        curHigh[0] <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        chk("trip drop", 32'h0, {31'h0, upTrip});
        apb(1'b1, ADDR_CMD, 32'h1);
        cmdOpen[0] <= 1'b0;
    endtask
    task automatic t_select();
        apb(1'b1, ADDR_CTRL, 32'h23);
        cmdOpen[1] <= 1'b1;
        repeat (3) @(posedge sys_clk);
        pulse(8'h01, 8'h00);
        state_is(4'h1);
    endtask
    task automatic wrap_up();
        if (miscompares == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset();
        t_current();
        t_modes();
        t_reject();
        t_combined();
        t_select();
        wrap_up();
    end
endmodule
`default_nettype wire
